// >>> branch_exec.sv
/*
  Execution unit for branch, call, return, compare and skip instructions of an
  8-bit RISC core. Owns the program counter and status flags register.
  Assumes the fetch path presents one decoded instruction with instr_valid for
  one cycle whenever ready is high, and that the stack returns pop_addr in the
  cycle after a pop request. All inputs are on the core clock.
*/
// What this block does
// RULE1: Relative jump loads PC+offset+1, keeps flags, takes two cycles.
// RULE2: Pointer jump loads the 16-bit pointer pair into PC, keeps flags, takes two cycles.
// RULE3: Absolute jump loads the address operand, keeps flags, takes three cycles.
// RULE4: Relative call loads PC+offset+1, keeps flags, takes three cycles.
// RULE5: Pointer call loads the pointer pair into PC, keeps flags, takes three cycles.
// RULE6: Absolute call loads the address operand, keeps flags, takes four cycles.
// RULE7: Subroutine return reloads PC from the stack, keeps flags, takes four cycles.
// RULE8: Interrupt return reloads PC from the stack, sets the interrupt enable, takes four cycles.
// RULE9: Compare-skip advances PC by two or three when registers are equal, keeps flags.
// RULE10: Compares subtract without storing and update Z, N, V, C, H (and S) in one cycle.
// RULE11: Register bit skips skip when the chosen bit is clear (or set), keeping flags.
// RULE12: I/O bit skips skip when the chosen I/O bit is clear (or set), keeping flags.
// RULE13: Branch-if-set adds offset+1 when the flag is one; one cycle untaken, two taken.
// RULE14: Branch-if-clear adds offset+1 when the flag is zero; one cycle untaken, two taken.
// RULE15: Every call pushes the next instruction address before the PC changes.
// RULE16: A skip adds two over a one-word and three over a two-word instruction, cycles follow.
// RULE17: Relative and branch offsets are signed two's complement.
`timescale 1ns/1ps
module branch_exec #(
  parameter int PC_BITS = branch_exec_pkg::PC_WIDTH
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic instr_valid,
  input wire branch_exec_pkg::instr_type instr,
  input wire logic [PC_BITS-1:0] pointer_pair,
  input wire logic [PC_BITS-1:0] pop_addr,
  output branch_exec_pkg::stack_req_type stack_req,
  output logic [PC_BITS-1:0] pc,
  output logic [7:0] status_flags_register,
  output logic ready,
  output logic done
);

  // Operand and stack widths are fixed by the package, so any other width is refused
  if (PC_BITS != branch_exec_pkg::PC_WIDTH) begin : g_width_check
    $error("PC_BITS must equal the package program counter width");
  end

  typedef enum logic [1:0] {idle_st, busy_st, pop_st} state_type;

  state_type state_ff;
  logic [PC_BITS-1:0] pc_ff;
  logic [PC_BITS-1:0] nxt_pc;
  logic [PC_BITS-1:0] pend_pc_ff;
  logic [7:0] flags_ff;
  logic [2:0] wait_ff;
  logic set_i_ff;
  logic ready_ff;
  logic done_ff;
  branch_exec_pkg::stack_req_type stack_ff;

  logic [PC_BITS-1:0] rel_target;
  logic [PC_BITS-1:0] ret_addr;
  logic [PC_BITS-1:0] skip_target;
  logic [2:0] skip_cycles;
  logic [2:0] cycles;
  logic is_call;
  logic is_return;
  logic is_skip;
  logic flag_bit;
  logic [8:0] diff;
  logic [4:0] half_diff;
  logic carry_in;
  logic [7:0] rhs;
  logic [7:0] nxt_flags;

  // Signed offset extended to PC width [RULE17]
  assign rel_target = pc_ff + {{(PC_BITS-branch_exec_pkg::REL_WIDTH){instr.offset[11]}},
                      instr.offset} + branch_exec_pkg::PC_STEP_ONE;
  assign ret_addr = pc_ff + branch_exec_pkg::PC_STEP_ONE;
  assign flag_bit = flags_ff[instr.bit_sel];

  // Skip distance depends on the length of the skipped instruction [RULE16]
  assign skip_target = instr.next_is_two_words ? pc_ff + branch_exec_pkg::PC_STEP_THREE
                                               : pc_ff + branch_exec_pkg::PC_STEP_TWO;
  assign skip_cycles = instr.next_is_two_words ? branch_exec_pkg::CYC_THREE
                                               : branch_exec_pkg::CYC_TWO;

  // Compare arithmetic, result discarded [RULE10]
  assign carry_in = (instr.op == branch_exec_pkg::compare_carry_op) &
                    flags_ff[branch_exec_pkg::FLAG_C];
  assign rhs = instr.src_val;
  assign diff = {1'b0, instr.dst_val} - {1'b0, rhs} - {8'h00, carry_in};
  assign half_diff = {1'b0, instr.dst_val[3:0]} - {1'b0, rhs[3:0]} - {4'h0, carry_in};

  always_comb begin
    nxt_pc = ret_addr;
    cycles = branch_exec_pkg::CYC_ONE;
    is_call = 1'b0;
    is_return = 1'b0;
    is_skip = 1'b0;
    nxt_flags = flags_ff;
    case (instr.op)
      branch_exec_pkg::relative_jump_op: begin
        nxt_pc = rel_target; // [RULE1]
        cycles = branch_exec_pkg::CYC_REL_JUMP;
      end
      branch_exec_pkg::pointer_jump_op: begin
        nxt_pc = pointer_pair; // [RULE2]
        cycles = branch_exec_pkg::CYC_PTR_JUMP;
      end
      branch_exec_pkg::absolute_jump_op: begin
        nxt_pc = instr.target; // [RULE3]
        cycles = branch_exec_pkg::CYC_ABS_JUMP;
      end
      branch_exec_pkg::relative_call_op: begin
        nxt_pc = rel_target; // [RULE4]
        cycles = branch_exec_pkg::CYC_REL_CALL;
        is_call = 1'b1;
      end
      branch_exec_pkg::pointer_call_op: begin
        nxt_pc = pointer_pair; // [RULE5]
        cycles = branch_exec_pkg::CYC_PTR_CALL;
        is_call = 1'b1;
      end
      branch_exec_pkg::absolute_call_op: begin
        nxt_pc = instr.target; // [RULE6]
        cycles = branch_exec_pkg::CYC_ABS_CALL;
        is_call = 1'b1;
      end
      branch_exec_pkg::subroutine_return_op,
      branch_exec_pkg::interrupt_return_op: begin
        cycles = branch_exec_pkg::CYC_RETURN; // [RULE7] [RULE8]
        is_return = 1'b1;
      end
      branch_exec_pkg::compare_skip_equal_op: begin
        is_skip = (instr.dst_val == instr.src_val); // [RULE9]
      end
      branch_exec_pkg::skip_reg_bit_clear_op: begin
        is_skip = ~instr.src_val[instr.bit_sel]; // [RULE11]
      end
      branch_exec_pkg::skip_reg_bit_set_op: begin
        is_skip = instr.src_val[instr.bit_sel]; // [RULE11]
      end
      branch_exec_pkg::skip_io_bit_clear_op: begin
        is_skip = ~instr.io_val[instr.bit_sel]; // [RULE12]
      end
      branch_exec_pkg::skip_io_bit_set_op: begin
        is_skip = instr.io_val[instr.bit_sel]; // [RULE12]
      end
      branch_exec_pkg::branch_flag_set_op: begin
        if (flag_bit) begin
          nxt_pc = rel_target; // [RULE13]
          cycles = branch_exec_pkg::CYC_TWO;
        end
      end
      branch_exec_pkg::branch_flag_clear_op: begin
        if (!flag_bit) begin
          nxt_pc = rel_target; // [RULE14]
          cycles = branch_exec_pkg::CYC_TWO;
        end
      end
      branch_exec_pkg::compare_op,
      branch_exec_pkg::compare_carry_op,
      branch_exec_pkg::compare_immediate_op: begin
        nxt_flags[branch_exec_pkg::FLAG_C] = diff[8]; // [RULE10]
        nxt_flags[branch_exec_pkg::FLAG_H] = half_diff[4];
        nxt_flags[branch_exec_pkg::FLAG_N] = diff[7];
        nxt_flags[branch_exec_pkg::FLAG_V] = (instr.dst_val[7] ^ rhs[7]) &
                                             (instr.dst_val[7] ^ diff[7]);
        nxt_flags[branch_exec_pkg::FLAG_S] = diff[7] ^ nxt_flags[branch_exec_pkg::FLAG_V];
        // Carry variant keeps Z set only if it was already set, for multi-byte chains
        if (instr.op == branch_exec_pkg::compare_carry_op) begin
          nxt_flags[branch_exec_pkg::FLAG_Z] = (diff[7:0] == 8'h00) &
                                               flags_ff[branch_exec_pkg::FLAG_Z];
        end else begin
          nxt_flags[branch_exec_pkg::FLAG_Z] = (diff[7:0] == 8'h00);
        end
      end
      default: begin
        nxt_pc = ret_addr;
      end
    endcase
    if (is_skip) begin
      nxt_pc = skip_target; // [RULE16]
      cycles = skip_cycles;
    end
  end

  // Sequencer: holds ready low for the remaining cycles of a multi-cycle op
  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= idle_st;
      wait_ff <= 3'h0;
      pend_pc_ff <= branch_exec_pkg::PC_RESET;
      set_i_ff <= 1'b0;
    end else begin
      case (state_ff)
        idle_st: begin
          if (instr_valid && cycles != branch_exec_pkg::CYC_ONE) begin
            wait_ff <= cycles - 3'h2;
            pend_pc_ff <= nxt_pc;
            set_i_ff <= (instr.op == branch_exec_pkg::interrupt_return_op);
            state_ff <= is_return ? pop_st : busy_st;
          end
        end
        pop_st: begin
          // Stack answers in the cycle after the pop strobe, so let one cycle pass first
          if (wait_ff == branch_exec_pkg::CYC_RETURN - 3'h2) begin
            wait_ff <= wait_ff - 3'h1;
          end else begin
            pend_pc_ff <= pop_addr; // [RULE7] [RULE8]
            wait_ff <= wait_ff - 3'h1;
            state_ff <= busy_st;
          end
        end
        busy_st: begin
          if (wait_ff == 3'h0) begin
            state_ff <= idle_st;
          end else begin
            wait_ff <= wait_ff - 3'h1;
          end
        end
        default: begin
          state_ff <= idle_st;
        end
      endcase
    end
  end

  // Program counter changes only on the last cycle, after any push
  always_ff @(posedge clock) begin
    if (rst) begin
      pc_ff <= branch_exec_pkg::PC_RESET;
    end else if (state_ff == idle_st && instr_valid && cycles == branch_exec_pkg::CYC_ONE) begin
      pc_ff <= nxt_pc;
    end else if (state_ff == busy_st && wait_ff == 3'h0) begin
      pc_ff <= pend_pc_ff;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      flags_ff <= branch_exec_pkg::FLAGS_RESET;
    end else if (state_ff == idle_st && instr_valid) begin
      flags_ff <= nxt_flags;
    end else if (state_ff == busy_st && wait_ff == 3'h0 && set_i_ff) begin
      flags_ff[branch_exec_pkg::FLAG_I] <= 1'b1; // [RULE8]
    end
  end

  // Push return address in the first cycle of a call; pop at start of a return
  always_ff @(posedge clock) begin
    if (rst) begin
      stack_ff <= '0;
    end else begin
      stack_ff.push <= (state_ff == idle_st) && instr_valid && is_call; // [RULE15]
      stack_ff.pop <= (state_ff == idle_st) && instr_valid && is_return;
      stack_ff.push_addr <= (state_ff == idle_st && instr_valid && is_call) ?
                            instr.next_is_two_words ? pc_ff + branch_exec_pkg::PC_STEP_TWO
                                                    : ret_addr
                            : stack_ff.push_addr;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ready_ff <= 1'b1;
      done_ff <= 1'b0;
    end else begin
      done_ff <= (state_ff == idle_st && instr_valid && cycles == branch_exec_pkg::CYC_ONE) ||
                 (state_ff == busy_st && wait_ff == 3'h0);
      ready_ff <= (state_ff == idle_st) ? !(instr_valid && cycles != branch_exec_pkg::CYC_ONE)
                                        : (state_ff == busy_st && wait_ff == 3'h0);
    end
  end

  assign pc = pc_ff;
  assign status_flags_register = flags_ff;
  assign stack_req = stack_ff;
  assign ready = ready_ff;
  assign done = done_ff;

endmodule

// >>> branch_exec_monitor.sv
/* Checker for branch_exec: pc targets, cycle counts, stack strobes and flags.
   Sees only the top module ports; bound from the testbench top file. */
`timescale 1ns/1ps
module branch_exec_monitor #(
  parameter int PC_BITS = branch_exec_pkg::PC_WIDTH
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic instr_valid,
  input wire branch_exec_pkg::instr_type instr,
  input wire logic [PC_BITS-1:0] pointer_pair,
  input wire logic [PC_BITS-1:0] pop_addr,
  input wire branch_exec_pkg::stack_req_type stack_req,
  input wire logic [PC_BITS-1:0] pc,
  input wire logic [7:0] status_flags_register,
  input wire logic ready,
  input wire logic done
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire logic tk = instr_valid && ready;
  // Offsets are signed, so backward targets wrap through the top of the space
  wire logic [PC_BITS-1:0] rel = PC_BITS'({{4{instr.offset[11]}}, instr.offset});
  a_rel_jump_pc: assert property (tk && instr.op == branch_exec_pkg::relative_jump_op |->
    ##2 done && pc == $past(pc, 2) + $past(rel, 2) + 1'b1) else $error("relative jump pc wrong");
  a_ptr_jump_pc: assert property (tk && instr.op == branch_exec_pkg::pointer_jump_op |->
    ##1 !ready ##1 done && pc == $past(pointer_pair, 2)) else $error("pointer jump wrong");
  a_abs_jump_wait: assert property (tk && instr.op == branch_exec_pkg::absolute_jump_op |->
    ##1 !ready [*2] ##1 done && pc == $past(instr.target, 3)) else $error("absolute jump wrong");
  a_ptr_call_pc: assert property (tk && instr.op == branch_exec_pkg::pointer_call_op |->
    ##3 done && pc == $past(pointer_pair, 3)) else $error("pointer call wrong");
  a_call_push_addr: assert property (tk && instr.op == branch_exec_pkg::absolute_call_op |->
    ##1 stack_req.push && stack_req.push_addr == $past(pc) + ($past(instr.next_is_two_words) ? 2 : 1)
    ##3 done && pc == $past(instr.target, 4)) else $error("absolute call wrong");
  a_ret_pop_pc: assert property (tk && instr.op == branch_exec_pkg::subroutine_return_op |->
    ##1 stack_req.pop ##3 done && pc == $past(pop_addr, 2)
    && status_flags_register == $past(status_flags_register, 4)) else $error("return wrong");
  a_interrupt_return_op_ienable: assert property (tk && instr.op == branch_exec_pkg::interrupt_return_op |->
    ##4 done && status_flags_register[7]) else $error("interrupt return wrong");
  a_branch_untaken: assert property (tk && instr.op == branch_exec_pkg::branch_flag_clear_op
    && status_flags_register[instr.bit_sel] |-> ##1 done && pc == $past(pc) + 1'b1)
    else $error("branch not taken wrong");
endmodule

// >>> branch_exec_pkg.sv
/*
  Package for the branch, call, return, compare and skip execution block:
  operation codes, status flag positions, cycle counts and carrier structs.
  Assumes a 16-bit word-addressed program counter and 8-bit data.
*/
package branch_exec_pkg;

  localparam int PC_WIDTH = 16;
  localparam int DATA_WIDTH = 8;
  localparam int REL_WIDTH = 12;
  localparam int COND_WIDTH = 7;

  // Status flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // Cycle counts per operation
  localparam logic [2:0] CYC_REL_JUMP = 3'h2;
  localparam logic [2:0] CYC_PTR_JUMP = 3'h2;
  localparam logic [2:0] CYC_ABS_JUMP = 3'h3;
  localparam logic [2:0] CYC_REL_CALL = 3'h3;
  localparam logic [2:0] CYC_PTR_CALL = 3'h3;
  localparam logic [2:0] CYC_ABS_CALL = 3'h4;
  localparam logic [2:0] CYC_RETURN = 3'h4;
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;

  localparam logic [15:0] PC_STEP_ONE = 16'h0001;
  localparam logic [15:0] PC_STEP_TWO = 16'h0002;
  localparam logic [15:0] PC_STEP_THREE = 16'h0003;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;

  typedef enum logic [4:0] {
    relative_jump_op,
    pointer_jump_op,
    absolute_jump_op,
    relative_call_op,
    pointer_call_op,
    absolute_call_op,
    subroutine_return_op,
    interrupt_return_op,
    compare_skip_equal_op,
    compare_op,
    compare_carry_op,
    compare_immediate_op,
    skip_reg_bit_clear_op,
    skip_reg_bit_set_op,
    skip_io_bit_clear_op,
    skip_io_bit_set_op,
    branch_flag_set_op,
    branch_flag_clear_op
  } op_type;

  // One decoded instruction handed to the block
  typedef struct packed {
    op_type op;
    logic [REL_WIDTH-1:0] offset;
    logic [PC_WIDTH-1:0] target;
    logic [DATA_WIDTH-1:0] dst_val;
    logic [DATA_WIDTH-1:0] src_val;
    logic [DATA_WIDTH-1:0] io_val;
    logic [2:0] bit_sel;
    logic next_is_two_words;
  } instr_type;

  // Stack handshake to the core stack
  typedef struct packed {
    logic push;
    logic pop;
    logic [PC_WIDTH-1:0] push_addr;
  } stack_req_type;

endpackage

// >>> branch_exec_test.sv
/* Testbench for branch_exec: a table of instructions, then back-to-back and reset cases.
   Drives every input at the rising edge; pc and flags come from its own model. */
`timescale 1ns/1ps
module branch_exec_test;
  typedef struct packed {
    branch_exec_pkg::instr_type i;
    logic [2:0] cyc;
    logic abs;
    logic [15:0] val;
  } row_type;
  logic clock, rst, instr_valid, ready, done;
  branch_exec_pkg::instr_type instr;
  branch_exec_pkg::stack_req_type stack_req;
  logic [15:0] pointer_pair, pop_addr, pc, exp_pc, pushed;
  logic [7:0] status_flags_register, exp_flags;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  row_type rows[21];
  branch_exec i_dut (.clock(clock), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .pointer_pair(pointer_pair), .pop_addr(pop_addr), .stack_req(stack_req), .pc(pc),
    .status_flags_register(status_flags_register), .ready(ready), .done(done));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors++;
      wrap_up();
    end
  end
  // Stack answers only in the cycle after the pop strobe; other cycles show a wrong address
  always @(posedge clock) begin
    pop_addr <= (stack_req.pop === 1'b1) ? 16'h4321 : 16'h0f0f;
  end
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] expd);
    total_checks++;
    if (seen !== expd) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, expd);
    end
  endtask
  // Compare flags; the carry variant only keeps Z set if it was already set
  function automatic logic [7:0] cmp(input logic [7:0] f, a, b, input logic cin, chain);
    logic [8:0] r;
    logic [7:0] n;
    r = {1'b0, a} - {1'b0, b} - {8'h00, cin};
    n = f;
    n[0] = r[8];
    n[1] = (r[7:0] == 8'h00) && (!chain || f[1]);
    n[2] = r[7];
    n[3] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    n[4] = n[2] ^ n[3];
    n[5] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    return n;
  endfunction
  function automatic row_type mk(input int o, k, t, d, s, p, b, w, c, a, v);
    mk = '{'{branch_exec_pkg::op_type'(o), k[11:0], t[15:0], d[7:0], s[7:0], p[7:0], b[2:0],
      w[0]}, c[2:0], a[0], v[15:0]};
  endfunction
  task automatic run(input row_type w);
    logic [15:0] old;
    int n;
    branch_exec_pkg::op_type o;
    old = exp_pc;
    o = w.i.op;
    n = 0;
    pushed = 16'h0000;
    @(posedge clock);
    instr <= w.i;
    instr_valid <= 1'b1;
    @(posedge clock);
    instr_valid <= 1'b0;
    do begin
      #1;
      n++;
      if (stack_req.push === 1'b1) pushed = stack_req.push_addr;
      if (done !== 1'b1) @(posedge clock);
    end while (done !== 1'b1 && n < 6);
    exp_pc = w.abs ? w.val : old + w.val;
    if (o == branch_exec_pkg::compare_op || o == branch_exec_pkg::compare_immediate_op)
      exp_flags = cmp(exp_flags, w.i.dst_val, w.i.src_val, 1'b0, 1'b0);
    if (o == branch_exec_pkg::compare_carry_op)
      exp_flags = cmp(exp_flags, w.i.dst_val, w.i.src_val, exp_flags[0], 1'b1);
    if (o == branch_exec_pkg::interrupt_return_op)
      exp_flags[7] = 1'b1;
    check(16'(n), 16'(w.cyc));
    check(pc, exp_pc);
    check({8'h00, status_flags_register}, {8'h00, exp_flags});
    if (o >= branch_exec_pkg::relative_call_op && o <= branch_exec_pkg::absolute_call_op)
      check(pushed, old + (w.i.next_is_two_words ? 16'h0002 : 16'h0001));
    $display("test op=%0d finished", o);
  endtask
  initial begin
    rst = 1'b1;
    instr_valid = 1'b0;
    instr = '0;
    pointer_pair = 16'h1234;
    exp_pc = 16'h0000;
    exp_flags = 8'h00;
    // Op codes follow the enum order of the package
    rows[0] = mk(9, 0, 0, 8'h10, 8'h20, 0, 0, 0, 1, 0, 1);
    rows[1] = mk(16, 12'hffe, 0, 0, 0, 0, 0, 0, 2, 0, 16'hffff);
    rows[2] = mk(17, 12'hffe, 0, 0, 0, 0, 0, 0, 1, 0, 1);
    rows[3] = mk(17, 5, 0, 0, 0, 0, 1, 0, 2, 0, 6);
    rows[4] = mk(0, 12'h800, 0, 0, 0, 0, 0, 0, 2, 0, 16'hf801);
    rows[5] = mk(1, 0, 0, 0, 0, 0, 0, 0, 2, 1, 16'h1234);
    rows[6] = mk(2, 0, 16'h0100, 0, 0, 0, 0, 0, 3, 1, 16'h0100);
    rows[7] = mk(3, 12'h010, 0, 0, 0, 0, 0, 0, 3, 0, 16'h0011);
    rows[8] = mk(4, 0, 0, 0, 0, 0, 0, 0, 3, 1, 16'h1234);
    rows[9] = mk(5, 0, 16'h2000, 0, 0, 0, 0, 1, 4, 1, 16'h2000);
    rows[10] = mk(6, 0, 0, 0, 0, 0, 0, 0, 4, 1, 16'h4321);
    rows[11] = mk(7, 0, 0, 0, 0, 0, 0, 0, 4, 1, 16'h4321);
    rows[12] = mk(8, 0, 0, 8'h5a, 8'h5a, 0, 0, 0, 2, 0, 2);
    rows[13] = mk(8, 0, 0, 8'h5a, 8'h5b, 0, 0, 1, 1, 0, 1);
    rows[14] = mk(8, 0, 0, 8'h5a, 8'h5a, 0, 0, 1, 3, 0, 3);
    rows[15] = mk(12, 0, 0, 8'h04, 8'h04, 0, 2, 0, 1, 0, 1);
    rows[16] = mk(13, 0, 0, 8'h04, 8'h04, 0, 2, 0, 2, 0, 2);
    rows[17] = mk(14, 0, 0, 0, 0, 8'h80, 7, 0, 1, 0, 1);
    rows[18] = mk(15, 0, 0, 0, 0, 8'h80, 7, 1, 3, 0, 3);
    rows[19] = mk(10, 0, 0, 8'h10, 8'h0f, 0, 0, 0, 1, 0, 1);
    rows[20] = mk(11, 0, 0, 8'h7f, 8'h80, 0, 0, 0, 1, 0, 1);
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    #1;
    check(pc, 16'h0000);
    check({14'h0000, ready, done}, 16'h0002);
    check({8'h00, status_flags_register}, 16'h0000);
    $display("test reset finished");
    foreach (rows[k]) run(rows[k]);
    // Two single-cycle compares on consecutive edges
    @(posedge clock);
    instr <= mk(9, 0, 0, 8'h01, 8'h02, 0, 0, 0, 0, 0, 0).i;
    instr_valid <= 1'b1;
    @(posedge clock);
    instr <= mk(11, 0, 0, 8'h80, 8'h01, 0, 0, 0, 0, 0, 0).i;
    @(posedge clock);
    instr_valid <= 1'b0;
    #1;
    exp_flags = cmp(cmp(exp_flags, 8'h01, 8'h02, 1'b0, 1'b0), 8'h80, 8'h01, 1'b0, 1'b0);
    exp_pc = exp_pc + 16'h0002;
    check(pc, exp_pc);
    check({8'h00, status_flags_register}, {8'h00, exp_flags});
    $display("test back to back finished");
    // Reset in the middle of a call must abandon it cleanly
    @(posedge clock);
    instr <= rows[9].i;
    instr_valid <= 1'b1;
    @(posedge clock);
    instr_valid <= 1'b0;
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    #1;
    check(pc, 16'h0000);
    check({14'h0000, ready, done}, 16'h0002);
    exp_pc = 16'h0000;
    exp_flags = 8'h00;
    run(rows[6]);
    $display("test mid reset finished");
    wrap_up();
  end
endmodule
bind branch_exec branch_exec_monitor #(.PC_BITS(PC_BITS)) i_mon (.clock(clock), .rst(rst),
  .instr_valid(instr_valid), .instr(instr), .pointer_pair(pointer_pair), .pop_addr(pop_addr),
  .stack_req(stack_req), .pc(pc), .status_flags_register(status_flags_register),
  .ready(ready), .done(done));
